// ==== inc/spreader_pkg.sv ====
// Constants, lookup tables and types shared by the chip spreader, the I/Q sink model and the bench.
// Assumes one 125 MHz clock; all rates below are derived from that figure.
//
// Function
// - Each byte is split into two 4-bit symbols and the low nibble is sent before the high one.
// - Each symbol value selects one of sixteen fixed 32-chip sequences from a constant table.
// - Chips leave at 2 Mchip/s, chip index zero first and then in ascending order.
// - Successive chips alternate between I and Q, with Q one half I-pulse later than I.
// - Every chip on I or Q is shaped as a half-sine pulse, which gives MSK-like O-QPSK.
// - The symbol bit stream and the chip stream can each be routed to an observation pin.
// - The table holds the sixteen listed sequences exactly, indexed by the symbol value.
package spreader_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Widths.
    localparam int BYTE_W = 8;
    localparam int NIB_W = 4;
    localparam int CHIPS = 32;
    localparam int IDX_W = 5;
    localparam int SYMBOLS = 16;
    localparam int FIFO_DEPTH_DEF = 16;
    localparam int SAMP_W = 8;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Timing: the chip clock comes from a fractional accumulator, so it averages 2 Mchip/s
    // exactly although 125 MHz is not a whole multiple of the chip rate.
    localparam int CLK_FREQ_MHZ = 125;
    localparam int CHIP_RATE_MCPS = 2;
    localparam int SAMPLES_PER_CHIP = 16;
    localparam int SUB_W = 4;
    localparam int ACC_W = 17;
    localparam int CLK_KHZ = CLK_FREQ_MHZ * 1000;
    localparam int CHIP_RATE_KHZ = CHIP_RATE_MCPS * 1000;
    localparam logic [ACC_W:0] CLK_MOD = (ACC_W + 1)'(CLK_KHZ);
    localparam logic [ACC_W:0] SAMPLE_STEP = (ACC_W + 1)'(CHIP_RATE_KHZ * SAMPLES_PER_CHIP);
    localparam int CHIP_CYC_MIN = CLK_KHZ / CHIP_RATE_KHZ;
    localparam int CHIP_CYC_MAX = CHIP_CYC_MIN + 1;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Counter landmarks.
    localparam logic [SUB_W-1:0] SUB_FIRST = 4'h0;
    localparam logic [SUB_W-1:0] SUB_LAST = 4'hF;
    localparam logic [IDX_W-1:0] CHIP_FIRST = 5'h00;
    localparam logic [IDX_W-1:0] CHIP_LAST = 5'h1F;
    localparam logic [IDX_W-1:0] CHIP_STEP = 5'h01;
    localparam logic [IDX_W-1:0] ROT_STEP = 5'h04;
    localparam logic [IDX_W-1:0] PEAK_PH = 5'h10;
    localparam logic [IDX_W-1:0] ZERO_PH = 5'h00;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Observation pin selections.
    localparam logic [1:0] OBS_OFF = 2'h0;
    localparam logic [1:0] OBS_BITS = 2'h1;
    localparam logic [1:0] OBS_CHIPS = 2'h2;
    localparam logic [1:0] OBS_CHIP_CLK = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Chip table: chip C0 sits in the most significant bit so that the hex reads like the
    // printed sequences.
    localparam logic [CHIPS-1:0] CHIP_LUT [SYMBOLS] = '{
        32'hD9C3_522E, 32'hED9C_3522, 32'h2ED9_C352, 32'h22ED_9C35,
        32'h522E_D9C3, 32'h3522_ED9C, 32'hC352_2ED9, 32'h9C35_22ED,
        32'h8C96_077B, 32'hB8C9_6077, 32'h7B8C_9607, 32'h77B8_C960,
        32'h077B_8C96, 32'h6077_B8C9, 32'h9607_7B8C, 32'hC960_77B8
    };

    // Rising half of sin(pi*k/32), k = 0..16, scaled to 127.
    localparam logic [6:0] SINE_LUT [0:16] = '{
        7'h00, 7'h0C, 7'h19, 7'h25, 7'h31, 7'h3C, 7'h47, 7'h51, 7'h5A,
        7'h62, 7'h6A, 7'h70, 7'h75, 7'h7A, 7'h7D, 7'h7E, 7'h7F
    };
    localparam logic [6:0] SINE_PEAK = 7'h7F;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Types.
    typedef struct packed {
        logic [SAMP_W-1:0] i;
        logic [SAMP_W-1:0] q;
    } iq_type;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_TAIL} state_type;

endpackage : spreader_pkg

// ==== design/byte_fifo.sv ====
// Synchronous first-in first-out buffer with valid/ready on both sides.
// Assumes one clock and an active-low reset that is already synchronised.
`timescale 1ns/1ns
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W:0] wr_reg;
    logic [PTR_W:0] rd_reg;
    logic full;
    logic empty;
    logic push;
    logic pop;

    // The extra pointer bit tells full from empty when the addresses match.
    assign empty = (wr_reg == rd_reg);
    assign full = (wr_reg[PTR_W] != rd_reg[PTR_W]) && (wr_reg[PTR_W-1:0] == rd_reg[PTR_W-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign push = in_valid && !full;
    assign pop = out_ready && !empty;
    assign out_data = mem[rd_reg[PTR_W-1:0]];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= push ? wr_reg + 1'h1 : wr_reg;
            rd_reg <= pop ? rd_reg + 1'h1 : rd_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg[PTR_W-1:0]] <= in_data;
        end
    end

endmodule : byte_fifo

// ==== design/chip_spreader.sv ====
// Transmit spreader: bytes in, half-sine shaped O-QPSK I/Q samples out.
// Assumes bytes come from logic on CLK; the modulator samples IQ_SAMPLE on every rising CLK edge.
`timescale 1ns/1ns
module chip_spreader
    import spreader_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // Byte stream from the frame engine
    input wire logic TX_VALID,
    input wire logic [BYTE_W-1:0] TX_DATA,
    output logic TX_READY,
    // Shaped baseband towards the modulator
    output iq_type IQ_SAMPLE,
    output logic TX_BUSY,
    // Observation pin
    input wire logic [1:0] OBS_SEL,
    output logic GPIO_OBS
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Reset release.
    logic rst_meta_reg;
    logic rst_n_reg;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_meta_reg <= 1'h0;
            rst_n_reg <= 1'h0;
        end else begin
            rst_meta_reg <= 1'h1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n_reg);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Byte buffer.
    logic fifo_valid;
    logic fifo_pop;
    logic [BYTE_W-1:0] fifo_data;

    byte_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) byte_fifo_i (
        .clk(CLK),
        .rst_n(rst_n_reg),
        .in_valid(TX_VALID),
        .in_ready(TX_READY),
        .in_data(TX_DATA),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////
    // State and timing registers.
    state_type state_reg;
    state_type state_next;
    logic [ACC_W-1:0] acc_reg;
    logic [ACC_W-1:0] acc_next;
    logic [SUB_W-1:0] sub_reg;
    logic [SUB_W-1:0] sub_next;
    logic [IDX_W-1:0] chip_idx_reg;
    logic [IDX_W-1:0] chip_idx_next;
    logic nib_reg;
    logic nib_next;
    logic [BYTE_W-1:0] byte_reg;
    logic [BYTE_W-1:0] byte_next;
    logic i_chip_reg;
    logic i_chip_next;
    logic q_chip_reg;
    logic q_chip_next;
    logic i_on_reg;
    logic i_on_next;
    logic q_on_reg;
    logic q_on_next;
    iq_type iq_reg;
    iq_type iq_next;
    logic obs_reg;
    logic obs_next;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Chip timing.
    logic running;
    logic [ACC_W:0] acc_sum;
    logic [ACC_W:0] acc_wrap;
    logic tick;
    logic chip_edge;
    logic run_edge;

    assign running = (state_reg != ST_IDLE);
    assign acc_sum = {1'h0, acc_reg} + SAMPLE_STEP;
    assign tick = (acc_sum >= CLK_MOD);
    assign acc_wrap = tick ? acc_sum - CLK_MOD : acc_sum;
    assign chip_edge = running && tick && (sub_reg == SUB_LAST);
    assign run_edge = chip_edge && (state_reg == ST_RUN);

    assign acc_next = running ? acc_wrap[ACC_W-1:0] : '0;
    assign sub_next = !running ? SUB_FIRST : (tick ? sub_reg + 1'h1 : sub_reg);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Symbol sequencing.
    logic start;
    logic sym_end;
    logic take_byte;
    logic [NIB_W-1:0] cur_sym;
    logic [NIB_W-1:0] load_sym;
    logic [IDX_W-1:0] step_idx;
    logic [IDX_W-1:0] load_idx;
    logic [CHIPS-1:0] load_seq;
    logic [CHIPS-1:0] cur_seq;
    logic load_chip;
    logic cur_chip;
    logic sym_bit;
    logic i_load;
    logic q_load;

    assign start = (state_reg == ST_IDLE) && fifo_valid;
    assign sym_end = run_edge && (chip_idx_reg == CHIP_LAST);
    // A new byte is taken while idle, or after the high nibble has gone out.
    assign fifo_pop = (state_reg == ST_IDLE) || (sym_end && nib_reg);
    assign take_byte = fifo_pop && fifo_valid;
    assign cur_sym = nib_reg ? byte_reg[BYTE_W-1:NIB_W] : byte_reg[NIB_W-1:0];
    assign load_sym = take_byte ? fifo_data[NIB_W-1:0] :
                      (sym_end ? byte_reg[BYTE_W-1:NIB_W] : cur_sym);
    assign step_idx = chip_idx_reg + CHIP_STEP;
    assign load_idx = start ? CHIP_FIRST : step_idx;
    assign load_seq = CHIP_LUT[load_sym];
    assign load_chip = load_seq[CHIP_LAST - load_idx];
    assign cur_seq = CHIP_LUT[cur_sym];
    assign cur_chip = cur_seq[CHIP_LAST - chip_idx_reg];
    // Eight chips carry one data bit, least significant bit of the symbol first.
    assign sym_bit = cur_sym[chip_idx_reg[IDX_W-1:IDX_W-2]];

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (fifo_valid) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (sym_end && nib_reg && !fifo_valid) begin
                    state_next = ST_TAIL;
                end
            end
            ST_TAIL: begin
                if (chip_edge) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    assign chip_idx_next = run_edge ? step_idx : chip_idx_reg;
    assign nib_next = take_byte ? 1'h0 : (sym_end ? !nib_reg : nib_reg);
    assign byte_next = take_byte ? fifo_data : byte_reg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // I takes the even chips and Q the odd ones; each pulse spans two chip times, so Q trails
    // I by half a pulse. The last Q pulse needs one more chip time, which is the tail state.
    assign i_load = start || (run_edge && !step_idx[0] && (state_next == ST_RUN));
    assign q_load = run_edge && step_idx[0];
    assign i_chip_next = i_load ? load_chip : i_chip_reg;
    assign q_chip_next = q_load ? load_chip : q_chip_reg;
    assign i_on_next = start ? 1'h1 : ((chip_edge && state_next != ST_RUN) ? 1'h0 : i_on_reg);
    assign q_on_next = start ? 1'h0 :
                       (q_load ? 1'h1 : ((state_next == ST_IDLE) ? 1'h0 : q_on_reg));

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Half-sine shaping.
    logic [IDX_W-1:0] i_ph;
    logic [IDX_W-1:0] q_ph;

    assign i_ph = {chip_idx_reg[0], sub_reg};
    assign q_ph = {!chip_idx_reg[0], sub_reg};

    function automatic logic [SAMP_W-1:0] shape(input logic on, input logic chip,
                                                 input logic [IDX_W-1:0] ph);
        logic [IDX_W-1:0] fold;
        logic [SAMP_W-1:0] mag;
        // The table holds the rising half only; the falling half reads it mirrored.
        fold = ph[IDX_W-1] ? (ZERO_PH - ph) : ph;
        mag = {1'h0, SINE_LUT[fold]};
        shape = !on ? '0 : (chip ? mag : '0 - mag);
    endfunction : shape

    assign iq_next = '{i: shape(i_on_reg, i_chip_reg, i_ph),
                       q: shape(q_on_reg, q_chip_reg, q_ph)};

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Observation pin.
    logic run_sym;
    logic chip_obs;

    assign run_sym = (state_reg == ST_RUN);
    assign chip_obs = cur_chip && run_sym;
    assign obs_next = (OBS_SEL == OBS_BITS) ? (sym_bit && run_sym) :
                      (OBS_SEL == OBS_CHIPS) ? chip_obs :
                      (OBS_SEL == OBS_CHIP_CLK) ? (sub_reg[SUB_W-1] && run_sym) :
                      1'h0;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Registers.
    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= ST_IDLE;
            acc_reg <= '0;
            sub_reg <= SUB_FIRST;
            chip_idx_reg <= CHIP_FIRST;
            nib_reg <= 1'h0;
            byte_reg <= '0;
        end else begin
            state_reg <= state_next;
            acc_reg <= acc_next;
            sub_reg <= sub_next;
            chip_idx_reg <= chip_idx_next;
            nib_reg <= nib_next;
            byte_reg <= byte_next;
        end
    end

    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            i_chip_reg <= 1'h0;
            q_chip_reg <= 1'h0;
            i_on_reg <= 1'h0;
            q_on_reg <= 1'h0;
            iq_reg <= '0;
            obs_reg <= 1'h0;
        end else begin
            i_chip_reg <= i_chip_next;
            q_chip_reg <= q_chip_next;
            i_on_reg <= i_on_next;
            q_on_reg <= q_on_next;
            iq_reg <= iq_next;
            obs_reg <= obs_next;
        end
    end

    assign IQ_SAMPLE = iq_reg;
    assign GPIO_OBS = obs_reg;
    assign TX_BUSY = running;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Checks.
    logic [6:0] gap_reg;
    logic gap_seen_reg;
    logic [IDX_W-1:0] rot_amt;

    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            gap_reg <= '0;
            gap_seen_reg <= 1'h0;
        end else begin
            gap_reg <= chip_edge ? '0 : gap_reg + 1'h1;
            gap_seen_reg <= chip_edge ? 1'h1 : (running ? gap_seen_reg : 1'h0);
        end
    end

    assign rot_amt = {1'h0, cur_sym[2:0], 1'h0} << 1;

    nibble_order_a: assert property ((sym_end && !nib_reg) |=>
        (nib_reg && $stable(byte_reg)))
        else $error("High nibble did not follow the low nibble.");
    low_first_a: assert property (take_byte |=>
        (!nib_reg && cur_sym == $past(fifo_data[NIB_W-1:0])))
        else $error("New byte did not start with its low nibble.");
    odd_table_a: assert property ((run_sym && cur_sym[3]) |->
        cur_chip == (CHIP_LUT[{1'h0, cur_sym[2:0]}][CHIP_LAST - chip_idx_reg] ^ chip_idx_reg[0]))
        else $error("Upper symbols are not the odd-chip inversion of the lower ones.");
    chip_order_a: assert property ((run_edge && chip_idx_reg != CHIP_LAST) |=>
        chip_idx_reg == $past(chip_idx_reg) + CHIP_STEP)
        else $error("Chip index did not advance by one.");
    chip_rate_a: assert property ((chip_edge && gap_seen_reg) |->
        (gap_reg == 7'(CHIP_CYC_MIN - 1) || gap_reg == 7'(CHIP_CYC_MAX - 1)))
        else $error("Chip spacing is not 62 or 63 clocks.");
    i_hold_a: assert property ((run_sym && chip_idx_reg[0] && $stable(chip_idx_reg)) |->
        $stable(i_chip_reg))
        else $error("I chip changed during an odd chip.");
    q_offset_a: assert property ($rose(q_on_reg) |->
        (chip_idx_reg == CHIP_STEP && sub_reg == SUB_FIRST))
        else $error("Q stream did not start one chip after I.");
    pulse_peak_a: assert property ((i_on_reg && i_ph == PEAK_PH) |=>
        (IQ_SAMPLE.i == {1'h0, SINE_PEAK} || IQ_SAMPLE.i == 8'h00 - {1'h0, SINE_PEAK}))
        else $error("I pulse is not at full swing mid-pulse.");
    pulse_zero_a: assert property ((q_on_reg && q_ph == ZERO_PH) |=> IQ_SAMPLE.q == 8'h00)
        else $error("Q pulse does not start from zero.");
    obs_chip_a: assert property ((OBS_SEL == OBS_CHIPS) |=> GPIO_OBS == $past(chip_obs))
        else $error("Observation pin does not show the chip stream.");
    rotate_a: assert property ((run_sym && cur_sym[2:0] > 3'h1) |-> cur_chip ==
        CHIP_LUT[{cur_sym[3], 3'h0}][CHIP_LAST - (chip_idx_reg - rot_amt)])
        else $error("Sequence is not the rotated base sequence.");
    sym_one_a: assert property ((run_sym && cur_sym == 4'h1) |->
        cur_chip == CHIP_LUT[0][CHIP_LAST - (chip_idx_reg - ROT_STEP)])
        else $error("Symbol one is not symbol zero rotated by four.");

    back_to_back_c: cover property (sym_end && nib_reg && fifo_valid);
    frame_end_c: cover property (state_reg == ST_TAIL ##1 state_reg == ST_IDLE);
    fifo_full_c: cover property (!TX_READY);
    bit_obs_c: cover property (OBS_SEL == OBS_BITS && GPIO_OBS);

endmodule : chip_spreader

// ==== bench/iq_sink.sv ====
// Modulator-side model: rebuilds the chip stream from the shaped I/Q samples.
// Assumes IQ_SAMPLE is taken on every rising CLK, as the DAC pair would take it.
`timescale 1ns/1ns
module iq_sink
    import spreader_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Shaped baseband
    input wire iq_type iq
);
    logic [7:0] i_abs;
    logic [7:0] q_abs;
    logic [7:0] i_last = 8'h00;
    logic [7:0] q_last = 8'h00;
    logic want_q = 1'b0;
    logic chips[$];
    int bad_shape = 0;
    int bad_gap = 0;
    int bad_rail = 0;
    int gap = -1;
    int quiet = 0;
    logic off_pace;

    function automatic logic on_curve(input logic [7:0] m);
        on_curve = 1'b0;
        for (int k = 0; k <= 16; k++) begin
            if (m == {1'b0, SINE_LUT[k]}) on_curve = 1'b1;
        end
    endfunction : on_curve

    assign i_abs = iq.i[7] ? 8'h00 - iq.i : iq.i;
    assign q_abs = iq.q[7] ? 8'h00 - iq.q : iq.q;
    assign off_pace = (gap >= 0) && ((gap + 1 < CHIP_CYC_MIN) || (gap + 1 > CHIP_CYC_MAX));

    ////////////////////////////////////////////////////////////////////////////
    // A chip is read at the first sample of its pulse peak; the sign is the chip.
    // A long run of zero samples means the frame is over, so timing restarts.
    always @(posedge clk) begin
        if (!on_curve(i_abs) || !on_curve(q_abs)) bad_shape <= bad_shape + 1;
        quiet <= (iq == '0) ? quiet + 1 : 0;
        gap <= (gap < 0) ? -1 : gap + 1;
        if (quiet > 8) begin
            gap <= -1;
            want_q <= 1'b0;
        end
        if (i_abs == 8'h7F && i_last != 8'h7F) begin
            chips.push_back(~iq.i[7]);
            if (want_q) bad_rail <= bad_rail + 1;
            want_q <= 1'b1;
            gap <= 0;
            if (off_pace) bad_gap <= bad_gap + 1;
        end
        if (q_abs == 8'h7F && q_last != 8'h7F) begin
            chips.push_back(~iq.q[7]);
            if (!want_q) bad_rail <= bad_rail + 1;
            want_q <= 1'b0;
            gap <= 0;
            if (off_pace) bad_gap <= bad_gap + 1;
        end
        i_last <= i_abs;
        q_last <= q_abs;
        // Samples taken before reset reaches the spreader are unknown, so drop what they left.
        if (!rst_b) begin
            bad_shape <= 0;
            i_last <= 8'h00;
            q_last <= 8'h00;
        end
    end
endmodule : iq_sink

// ==== bench/chip_spreader_tb.sv ====
// Self-checking bench for the chip spreader, with the modulator model on its I/Q side.
// Assumes the package, the buffer and the spreader are compiled before this file.
`timescale 1ns/1ns
module chip_spreader_tb
    import spreader_pkg::*;
();
    // A shallow buffer keeps the fill and drain scenario short.
    localparam int FD = 4;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic tx_valid = 1'b0;
    logic [BYTE_W-1:0] tx_data = 8'h00;
    logic [1:0] obs_sel = OBS_OFF;
    logic tx_ready;
    logic tx_busy;
    logic gpio_obs;
    iq_type iq_sample;
    int err_total = 0;
    int checked = 0;
    logic [7:0] sent[$];

    initial begin
        forever #4 clk = ~clk;
    end

    chip_spreader #(.FIFO_DEPTH(FD)) chip_spreader_i (.CLK(clk), .RST_B(rst_b),
        .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready), .IQ_SAMPLE(iq_sample),
        .TX_BUSY(tx_busy), .OBS_SEL(obs_sel), .GPIO_OBS(gpio_obs));
    iq_sink iq_sink_i (.clk(clk), .rst_b(rst_b), .iq(iq_sample));

    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp_vec(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_vec

    task automatic test_done();
        $display("Counts: %0d compared, %0d mismatched", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    task automatic give_up(input string what);
        err_total++;
        $display("[ERR] %s expected done seen timeout", what);
        test_done();
    endtask : give_up

    // Symbols 1..7 and 9..15 are chip rotations of symbols 0 and 8.
    function automatic logic [31:0] exp_seq(input logic [3:0] sym);
        logic [31:0] base;
        logic [5:0] r;
        base = sym[3] ? 32'hD9C3_522E ^ 32'h0 : 32'hD9C3_522E;
        if (sym[3]) base = 32'h8C96_077B;
        r = {1'b0, sym[2:0], 2'h0};
        exp_seq = (base >> r) | (base << (6'h20 - r));
    endfunction : exp_seq

    task automatic push(input logic [7:0] b);
        logic rdy;
        tx_valid <= 1'b1;
        tx_data <= b;
        for (int n = 0; n < 20000; n++) begin
            @(negedge clk);
            rdy = tx_ready;
            @(posedge clk);
            if (rdy) begin
                sent.push_back(b);
                return;
            end
        end
        give_up("byte accept");
    endtask : push

    task automatic wait_busy();
        for (int n = 0; n < 10; n++) begin
            @(negedge clk);
            if (tx_busy === 1'b1) return;
        end
        give_up("busy rise");
    endtask : wait_busy

    // Waits out the frame, then matches every chip seen against the sent bytes.
    task automatic run_out(input string name);
        logic [31:0] word;
        logic [3:0] sym;
        wait_busy();
        for (int n = 0; n < 40000 && tx_busy !== 1'b0; n++) @(negedge clk);
        if (tx_busy !== 1'b0) give_up("frame end");
        repeat (2) @(negedge clk);
        cmp_vec("idle iq", 32'h0, 32'(iq_sample));
        cmp_vec("chip count", 32'(64 * sent.size()), 32'(iq_sink_i.chips.size()));
        foreach (sent[k]) begin
            for (int h = 0; h < 2; h++) begin
                for (int c = 0; c < 32; c++) word = {word[30:0], iq_sink_i.chips.pop_front()};
                sym = h ? sent[k][7:4] : sent[k][3:0];
                cmp_vec("symbol chips", exp_seq(sym), word);
            end
        end
        cmp_vec("pulse shape", 32'h0, 32'(iq_sink_i.bad_shape));
        cmp_vec("chip spacing", 32'h0, 32'(iq_sink_i.bad_gap));
        cmp_vec("rail order", 32'h0, 32'(iq_sink_i.bad_rail));
        sent.delete();
        iq_sink_i.chips.delete();
        $display("%s finished", name);
    endtask : run_out

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        repeat (2) @(negedge clk);
        cmp_vec("reset busy", 32'h0, 32'(tx_busy));
        cmp_vec("reset iq", 32'h0, 32'(iq_sample));
        cmp_vec("reset obs", 32'h0, 32'(gpio_obs));
        cmp_vec("reset ready", 32'h1, 32'(tx_ready));
        @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        $display("test_reset finished");
    endtask : test_reset

    task automatic test_all_symbols();
        logic [63:0] field;
        field = 64'hFEDC_BA98_7654_3210;
        @(posedge clk);
        for (int k = 0; k < 8; k++) push(field[8*k +: 8]);
        tx_valid <= 1'b0;
        run_out("test_all_symbols");
    endtask : test_all_symbols

    task automatic test_fill();
        logic rdy;
        @(posedge clk);
        tx_valid <= 1'b1;
        tx_data <= 8'hA0;
        for (int n = 0; n < 4 * FD; n++) begin
            @(negedge clk);
            rdy = tx_ready;
            @(posedge clk);
            if (!rdy) break;
            sent.push_back(tx_data);
            tx_data <= tx_data + 8'h11;
        end
        cmp_vec("accepted", 32'(FD + 1), 32'(sent.size()));
        for (int n = 0; n < 5; n++) begin
            @(negedge clk);
            cmp_vec("refusing", 32'h0, 32'(tx_ready));
        end
        @(posedge clk);
        tx_valid <= 1'b0;
        run_out("test_fill");
    endtask : test_fill

    task automatic test_observe(input logic [1:0] mode, input logic [7:0] b);
        int t;
        int off;
        logic exp;
        logic [31:0] seq;
        @(posedge clk);
        obs_sel <= mode;
        push(b);
        tx_valid <= 1'b0;
        wait_busy();
        t = 0;
        for (int k = 0; k < ((mode[1]) ? 64 : 8); k++) begin
            off = 250 + 500 * k;
            exp = (mode == OBS_BITS) ? b[k % 8] : 1'b0;
            seq = exp_seq((k < 32) ? b[3:0] : b[7:4]);
            if (mode == OBS_CHIPS) begin
                off = (125 * k + 62) / 2;
                exp = seq[31 - (k % 32)];
            end
            if (mode == OBS_CHIP_CLK) begin
                off = (125 * (k / 2) + 31 + 62 * (k % 2)) / 2;
                exp = k % 2;
            end
            while (t < off) begin
                @(negedge clk);
                t++;
            end
            cmp_vec("obs pin", 32'(exp), 32'(gpio_obs));
        end
        run_out("test_observe");
    endtask : test_observe

    initial begin
        test_reset();
        test_all_symbols();
        test_fill();
        test_observe(OBS_OFF, 8'h5A);
        test_observe(OBS_BITS, 8'h5A);
        test_observe(OBS_CHIPS, 8'h3C);
        test_observe(OBS_CHIP_CLK, 8'h96);
        test_done();
    end
endmodule : chip_spreader_tb
